// File: testbench/afic_cmd_exec_chk.sv
// Port checker of the command executor, bound to its top level
`timescale 1ns/10ps
module afic_cmd_exec_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_valid,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [4:0]  flag_set,
  input wire logic [31:0] irq_req,
  input wire logic [31:0] irq_service,
  input wire logic [4:0]  error_flags,
  input wire logic        axis_param_we,
  input wire logic        global_param_we,
  input wire logic [7:0]  global_param_bank
);
  logic [3:0] cnt;
  logic [7:0] sum;
  logic [7:0] adr;
  logic       fr_end;
  assign fr_end = rx_valid && cnt == 4'h8;
  // Frame byte count, running sum and target address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      sum <= 8'h00;
      adr <= 8'h00;
    end else if (rx_valid) begin
      cnt <= fr_end ? 4'h0 : cnt + 4'h1;
      sum <= fr_end ? 8'h00 : sum + rx_byte;
      adr <= (cnt == 4'h0) ? rx_byte : adr;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_reply_ok;
    fr_end && rx_byte == sum && adr == 8'h01 && !tx_valid
      |-> ##4 !tx_valid ##1 tx_valid && tx_byte == 8'h02;
  endproperty
  a_reply_ok: assert property (p_reply_ok) else $error("reply late or wrong");
  property p_chk_bad;
    fr_end && rx_byte != sum && !tx_valid |=> !tx_valid [*6];
  endproperty
  a_chk_bad: assert property (p_chk_bad) else $error("bad frame answered");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
  property p_axis_reply;
    axis_param_we |=> !axis_param_we ##1 tx_valid && tx_byte == 8'h02;
  endproperty
  a_axis_reply: assert property (p_axis_reply) else $error("axis write pulse");
  property p_glob_bank;
    global_param_we |-> global_param_bank inside {8'h00, 8'h02, 8'h03};
  endproperty
  a_glob_bank: assert property (p_glob_bank) else $error("illegal bank");
  property p_flag_set;
    |flag_set |=> (error_flags & $past(flag_set)) == $past(flag_set);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_flag_clr;
    |($past(error_flags) & ~error_flags) |-> ##[1:2] tx_valid;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag cleared alone");
  property p_svc;
    (irq_service & ~$past(irq_req)) == 32'h0000_0000;
  endproperty
  a_svc: assert property (p_svc) else $error("service without request");
  c_frame: cover property (fr_end);
  c_axis: cover property (axis_param_we);
  c_glob: cover property (global_param_we);
  c_svc: cover property (|irq_service);
endmodule

bind afic_cmd_exec afic_cmd_exec_chk i_chk (
  .clk(clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .flag_set(flag_set), .irq_req(irq_req),
  .irq_service(irq_service), .error_flags(error_flags), .axis_param_we(axis_param_we),
  .global_param_we(global_param_we), .global_param_bank(global_param_bank)
);

// File: testbench/afic_cmd_exec_tb.sv
// Self-checking bench of the command executor
`timescale 1ns/10ps
module afic_cmd_exec_tb;
  logic        clk, rst, rx_valid, tx_valid, tx_ready, bus_wr, bus_rd, irq, slow;
  logic        axis_param_we, global_param_we;
  logic [7:0]  rx_byte, tx_byte, bus_addr, axis_param_idx, global_param_bank, global_param_idx;
  logic [31:0] bus_wdata, bus_rdata, irq_req, irq_service, param_data;
  logic [4:0]  flag_set, error_flags;
  logic [47:0] ax, gl;
  int          ax_n, gl_n, k, num_errors, samples_checked;
  afic_cmd_exec i_dut (.clk(clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .flag_set(flag_set), .irq_req(irq_req), .irq_service(irq_service), .irq(irq),
    .error_flags(error_flags), .axis_param_we(axis_param_we),
    .axis_param_idx(axis_param_idx), .global_param_we(global_param_we),
    .global_param_bank(global_param_bank), .global_param_idx(global_param_idx),
    .param_data(param_data));
  afic_host_model i_host (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Parameter write monitor
  always @(posedge clk) begin
    if (axis_param_we) ax_n <= ax_n + 1;
    if (axis_param_we) ax <= {8'h00, axis_param_idx, param_data};
    if (global_param_we) gl_n <= gl_n + 1;
    if (global_param_we) gl <= {global_param_bank, global_param_idx, param_data};
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), 48'(bus_rdata), 48'(e));
  endtask
  task automatic cmd(input logic [7:0] op, ty, bk, input logic [7:0] st);
    logic [7:0] s;
    int         n;
    i_host.send({8'h01, op, ty, bk, 32'h0000_0000}, 1'b0);
    for (n = 0; n < 400 && i_host.rep_n < 9; n++) @(posedge clk);
    if (i_host.rep_n < 9) begin
      num_errors++;
      print_verdict();
    end
    s = 8'h00;
    for (n = 0; n < 8; n++) s = s + i_host.rep[n];
    check("host addr", 48'(i_host.rep[0]), 48'h0000_0000_0002);
    check("target", 48'(i_host.rep[1]), 48'h0000_0000_0001);
    check("status", 48'(i_host.rep[2]), 48'(st));
    check("instr", 48'(i_host.rep[3]), 48'(op));
    check("reply sum", 48'(i_host.rep[8]), 48'(s));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, bus_wr, bus_rd, slow} = 4'h8;
    {bus_addr, bus_wdata, flag_set, irq_req} = '0;
    {ax, gl, ax_n, gl_n, k, num_errors, samples_checked} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    wr(8'h00, 32'h1234_5678);
    rd(8'h00, 32'h1234_5678);
    slow <= 1'b1;
    cmd(8'h22, 8'h05, 8'h00, 8'h64);
    slow <= 1'b0;
    check("axis", ax, 48'h0005_1234_5678);
    cmd(8'h22, 8'h06, 8'h01, 8'h04);
    check("axis count", 48'(ax_n), 48'h0000_0000_0001);
    for (logic [7:0] b = 8'h00; b < 8'h04; b++) begin
      cmd(8'h23, 8'h2A, b, (b == 8'h01) ? 8'h04 : 8'h64);
      k = k + ((b == 8'h01) ? 0 : 1);
      check("glob count", 48'(gl_n), 48'(k));
      if (b != 8'h01) check("glob", gl, {b, 8'h2A, 32'h1234_5678});
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      flag_set <= 5'h1F;
      @(posedge clk);
      flag_set <= 5'h00;
      cmd(8'h24, 8'(i), 8'h00, 8'h64);
      rd(8'h08, (i == 0) ? 32'h0 : 32'(5'h1F & ~(5'h01 << (i - 1))));
    end
    wr(8'h08, 32'h0000_001F);
    rd(8'h08, 32'h0000_000F);
    cmd(8'h24, 8'h06, 8'h00, 8'h03);
    irq_req <= 32'hFFFF_FFFF;
    cmd(8'h19, 8'h1F, 8'h00, 8'h64);
    rd(8'h0C, 32'h8000_0000);
    check("svc", 48'(irq_service), 48'h0);
    cmd(8'h19, 8'hFF, 8'h00, 8'h64);
    rd(8'h10, 32'h0000_0001);
    check("svc", 48'(irq_service), 48'h0000_8000_0000);
    cmd(8'h1A, 8'h1F, 8'h00, 8'h64);
    rd(8'h0C, 32'h0000_0000);
    check("svc", 48'(irq_service), 48'h0);
    cmd(8'h19, 8'h00, 8'h00, 8'h64);
    cmd(8'h1A, 8'hFF, 8'h00, 8'h64);
    rd(8'h10, 32'h0000_0000);
    check("svc", 48'(irq_service), 48'h0);
    cmd(8'h21, 8'h02, 8'h00, 8'h02);
    check("irq masked", 48'(irq), 48'h0);
    wr(8'h18, 32'h0000_0001);
    rd(8'h18, 32'h0000_0001);
    check("irq", 48'(irq), 48'h1);
    wr(8'h14, 32'h0000_000F);
    rd(8'h14, 32'h0000_0000);
    check("irq clear", 48'(irq), 48'h0);
    i_host.send({8'h01, 8'h22, 8'h00, 8'h00, 32'h0000_0000}, 1'b1);
    i_host.send({8'h05, 8'h22, 8'h00, 8'h00, 32'h0000_0000}, 1'b0);
    repeat (20) @(posedge clk);
    check("no reply", 48'(i_host.rep_n), 48'h0);
    check("axis count", 48'(ax_n), 48'h0000_0000_0001);
    rd(8'h14, 32'h0000_0002);
    print_verdict();
  end
endmodule

// File: testbench/afic_host_model.sv
// Host model: sends command frames, takes replies, may stall
`timescale 1ns/10ps
module afic_host_model (
  input  wire logic       clk,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       slow
);
  logic [7:0] rep [0:8];
  int         rep_n;
  logic       ph;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    rep_n = 0;
    ph = 1'b0;
  end
  // Reply capture, ready every other cycle when slow
  always @(posedge clk) begin
    ph <= ~ph;
    tx_ready <= !slow || ph;
    if (tx_valid && tx_ready && rep_n < 9) begin
      rep[rep_n] <= tx_byte;
      rep_n <= rep_n + 1;
    end
  end
  task automatic send(input logic [63:0] body, input logic bad);
    logic [7:0] s;
    s = 8'h00;
    rep_n = 0;
    for (int i = 7; i >= 0; i--) begin
      s = s + body[i*8 +: 8];
      @(posedge clk);
      rx_byte <= body[i*8 +: 8];
      rx_valid <= 1'b1;
    end
    s = s + {7'h00, bad};
    @(posedge clk);
    rx_byte <= s;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~s;
  endtask
endmodule

// File: verilog/afic_cmd_exec.sv
// Accumulator, error flag and interrupt command executor, top level
//
// Operation
// - Code 34 copies accumulator to axis parameter by type, motor 0 only.
// - Code 35 copies accumulator to global parameter by type in bank 0, 2, 3.
// - Code 36 clears error flags: type 0 all, 1 to 5 one each.
// - Code 25 enables the interrupt source numbered by type.
// - Code 25 with number 255 sets the global interrupt enable.
// - Code 26 disables the interrupt source numbered by type.
// - Code 26 with number 255 clears the global interrupt enable.
// - Frame is address, instruction, type, bank, four value bytes MSB first, checksum.
// - Reply is host address, target, status, instruction, value; success is 0x64.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "afic_defs.svh"
module afic_cmd_exec (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic [4:0]  flag_set,
  input  wire logic [31:0] irq_req,
  output logic      [31:0] irq_service,
  output logic             irq,
  output logic      [4:0]  error_flags,
  output logic             axis_param_we,
  output logic      [7:0]  axis_param_idx,
  output logic             global_param_we,
  output logic      [7:0]  global_param_bank,
  output logic      [7:0]  global_param_idx,
  output logic      [31:0] param_data
);
  afic_frame_if fi ();

  afic_pkg::afic_state_e state;
  afic_pkg::afic_frame_s cmd;
  logic [31:0]           accu;
  logic [7:0]            mod_addr;
  logic [31:0]           irq_en;
  logic                  global_en;
  logic [3:0]            evt_status;
  logic [3:0]            evt_mask;
  logic [3:0]            evt_set;
  logic [7:0]            status;
  logic                  exec_ok;
  logic [4:0]            flag_clr;
  logic                  do_exec;
  logic                  exec_axis;
  logic                  exec_global;
  logic                  exec_clear;
  logic                  exec_ien;
  logic                  exec_idis;
  logic                  exec_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver and reply sender
  afic_frame_rx u_rx (
    .clk      (clk),
    .rst      (rst),
    .rx_byte  (rx_byte),
    .rx_valid (rx_valid),
    .fi       (fi.rx)
  );

  afic_reply_tx u_tx (
    .clk      (clk),
    .rst      (rst),
    .tx_byte  (tx_byte),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .fi       (fi.tx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command check, giving the reply status
  function automatic logic [7:0] cmd_status(input afic_pkg::afic_frame_s f);
    logic [7:0] s;
    s = `AFIC_ST_OK;
    unique case (f.instr)
      `AFIC_OP_ACCU_AXIS: begin
        if (f.bank != 8'h00) s = `AFIC_ST_BAD_VALUE;
      end
      `AFIC_OP_ACCU_GLOBAL: begin
        if (f.bank == 8'h01 || f.bank > 8'h03) s = `AFIC_ST_BAD_VALUE;
      end
      `AFIC_OP_CLEAR_FLAGS: begin
        if (f.typ > `AFIC_CLR_LAST) s = `AFIC_ST_BAD_TYPE;
      end
      `AFIC_OP_IRQ_ENABLE, `AFIC_OP_IRQ_DISABLE: begin
        if (f.typ > 8'h1F && f.typ != `AFIC_IRQ_GLOBAL_NUM) s = `AFIC_ST_BAD_TYPE;
      end
      default: s = `AFIC_ST_BAD_CMD;
    endcase
    return s;
  endfunction

  assign status  = cmd_status(cmd);
  assign exec_ok = (status == `AFIC_ST_OK);
  assign do_exec = (state == afic_pkg::AFIC_EXEC) && exec_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Executed command strobes, one per instruction code
  function automatic logic op_hit(input logic       go,
                                  input logic [7:0] op,
                                  input logic [7:0] code);
    return go && (op == code);
  endfunction

  // High only in the execute cycle of an accepted command
  assign exec_axis   = op_hit(do_exec, cmd.instr, `AFIC_OP_ACCU_AXIS);
  assign exec_global = op_hit(do_exec, cmd.instr, `AFIC_OP_ACCU_GLOBAL);
  assign exec_clear  = op_hit(do_exec, cmd.instr, `AFIC_OP_CLEAR_FLAGS);
  assign exec_ien    = op_hit(do_exec, cmd.instr, `AFIC_OP_IRQ_ENABLE);
  assign exec_idis   = op_hit(do_exec, cmd.instr, `AFIC_OP_IRQ_DISABLE);
  // Refused command: answered with its status, sets only the bad-command event
  assign exec_bad    = (state == afic_pkg::AFIC_EXEC) && !exec_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= afic_pkg::AFIC_IDLE;
      cmd   <= '0;
    end else begin
      unique case (state)
        afic_pkg::AFIC_IDLE: begin
          if (fi.frm_valid && fi.frm_chk_ok && fi.frm.addr == mod_addr) begin
            cmd   <= fi.frm;
            state <= afic_pkg::AFIC_EXEC;
          end
        end
        afic_pkg::AFIC_EXEC: begin
          state <= afic_pkg::AFIC_REPLY;
        end
        afic_pkg::AFIC_REPLY: begin
          if (!fi.rep_busy) state <= afic_pkg::AFIC_IDLE;
        end
        default: state <= afic_pkg::AFIC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply launch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fi.rep_start <= 1'b0;
      fi.rep_bytes <= 64'h0000_0000_0000_0000;
    end else begin
      fi.rep_start <= (state == afic_pkg::AFIC_REPLY) && !fi.rep_busy;
      if (state == afic_pkg::AFIC_EXEC) begin
        fi.rep_bytes <= {`AFIC_HOST_ADDR, mod_addr, status, cmd.instr, 32'h0000_0000};
      end
    end
  end
  // Status 0x64 marks success; the value field is left at zero.

  ////////////////////////////////////////////////////////////////////////////
  // Parameter writes from the accumulator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      axis_param_we     <= 1'b0;
      axis_param_idx    <= 8'h00;
      global_param_we   <= 1'b0;
      global_param_bank <= 8'h00;
      global_param_idx  <= 8'h00;
      param_data        <= 32'h0000_0000;
    end else begin
      axis_param_we   <= exec_axis;
      global_param_we <= exec_global;
      if (do_exec) begin
        axis_param_idx    <= cmd.typ;
        global_param_idx  <= cmd.typ;
        global_param_bank <= cmd.bank;
        param_data        <= accu;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flags, set wins over clear
  always_comb begin
    flag_clr = 5'h00;
    if (exec_clear) begin
      if (cmd.typ == `AFIC_CLR_ALL) begin
        flag_clr = 5'h1F;
      end else begin
        flag_clr = 5'h01 << (cmd.typ[2:0] - 3'h1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_flags <= 5'h00;
    end else begin
      error_flags <= (error_flags & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt source and global enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en    <= 32'h0000_0000;
      global_en <= 1'b0;
    end else if (exec_ien) begin
      if (cmd.typ == `AFIC_IRQ_GLOBAL_NUM) begin
        global_en <= 1'b1;
      end else begin
        irq_en[cmd.typ[4:0]] <= 1'b1;
      end
    end else if (exec_idis) begin
      if (cmd.typ == `AFIC_IRQ_GLOBAL_NUM) begin
        global_en <= 1'b0;
      end else begin
        irq_en[cmd.typ[4:0]] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_service <= 32'h0000_0000;
    end else begin
      irq_service <= irq_req & irq_en & {32{global_en}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt line
  always_comb begin
    evt_set = 4'h0;
    evt_set[`AFIC_EVT_DONE]    = do_exec;
    evt_set[`AFIC_EVT_CHK_ERR] = fi.frm_valid && !fi.frm_chk_ok;
    evt_set[`AFIC_EVT_BAD_CMD] = exec_bad;
    evt_set[`AFIC_EVT_OVERRUN] = fi.frm_valid && (state != afic_pkg::AFIC_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status <= 4'h0;
    end else begin
      if (bus_wr && bus_addr == `AFIC_REG_EVT_STATUS) begin
        evt_status <= (evt_status & ~bus_wdata[3:0]) | evt_set;
      end else begin
        evt_status <= evt_status | evt_set;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accu     <= 32'h0000_0000;
      mod_addr <= `AFIC_MOD_ADDR_RST;
      evt_mask <= 4'h0;
    end else if (bus_wr) begin
      unique case (bus_addr)
        `AFIC_REG_ACCU:     accu     <= bus_wdata;
        `AFIC_REG_MOD_ADDR: mod_addr <= bus_wdata[7:0];
        `AFIC_REG_EVT_MASK: evt_mask <= bus_wdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      unique case (bus_addr)
        `AFIC_REG_ACCU:       bus_rdata <= accu;
        `AFIC_REG_MOD_ADDR:   bus_rdata <= {24'h00_0000, mod_addr};
        `AFIC_REG_ERR_FLAGS:  bus_rdata <= {27'h000_0000, error_flags};
        `AFIC_REG_IRQ_EN:     bus_rdata <= irq_en;
        `AFIC_REG_GLOBAL_EN:  bus_rdata <= {31'h0000_0000, global_en};
        `AFIC_REG_EVT_STATUS: bus_rdata <= {28'h000_0000, evt_status};
        `AFIC_REG_EVT_MASK:   bus_rdata <= {28'h000_0000, evt_mask};
        `AFIC_REG_LAST_CMD:   bus_rdata <= {8'h00, cmd.instr, cmd.typ, cmd.bank};
        default:              bus_rdata <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end
endmodule

// File: verilog/afic_defs.svh
// Offsets, field positions, codes and reset values of the command executor
`ifndef AFIC_DEFS_SVH
`define AFIC_DEFS_SVH

// Instruction codes
`define AFIC_OP_ACCU_AXIS     8'h22
`define AFIC_OP_ACCU_GLOBAL   8'h23
`define AFIC_OP_CLEAR_FLAGS   8'h24
`define AFIC_OP_IRQ_ENABLE    8'h19
`define AFIC_OP_IRQ_DISABLE   8'h1A

// Type byte values
`define AFIC_IRQ_GLOBAL_NUM   8'hFF
`define AFIC_CLR_ALL          8'h00
`define AFIC_CLR_LAST         8'h05

// Reply status codes
`define AFIC_ST_OK            8'h64
`define AFIC_ST_BAD_CMD       8'h02
`define AFIC_ST_BAD_TYPE      8'h03
`define AFIC_ST_BAD_VALUE     8'h04

// Frame layout
`define AFIC_FRAME_BODY       4'h8
`define AFIC_HOST_ADDR        8'h02
`define AFIC_MOD_ADDR_RST     8'h01

// Register byte offsets
`define AFIC_REG_ACCU         8'h00
`define AFIC_REG_MOD_ADDR     8'h04
`define AFIC_REG_ERR_FLAGS    8'h08
`define AFIC_REG_IRQ_EN       8'h0C
`define AFIC_REG_GLOBAL_EN    8'h10
`define AFIC_REG_EVT_STATUS   8'h14
`define AFIC_REG_EVT_MASK     8'h18
`define AFIC_REG_LAST_CMD     8'h1C

// Event bit positions
`define AFIC_EVT_DONE         0
`define AFIC_EVT_CHK_ERR      1
`define AFIC_EVT_BAD_CMD      2
`define AFIC_EVT_OVERRUN      3

// Error flag bit positions
`define AFIC_FLG_TIMEOUT      0
`define AFIC_FLG_ALARM        1
`define AFIC_FLG_DEVIATION    2
`define AFIC_FLG_POSITION     3
`define AFIC_FLG_SHUTDOWN     4

`endif

// File: verilog/afic_frame_if.sv
// Carrier between frame receiver, executor and reply sender
`timescale 1ns/10ps
interface afic_frame_if;
  logic                frm_valid;
  logic                frm_chk_ok;
  afic_pkg::afic_frame_s frm;
  logic                rep_start;
  logic [63:0]         rep_bytes;
  logic                rep_busy;

  modport rx (output frm_valid, output frm_chk_ok, output frm);
  modport exec (input frm_valid, input frm_chk_ok, input frm, input rep_busy,
                output rep_start, output rep_bytes);
  modport tx (input rep_start, input rep_bytes, output rep_busy);
endinterface

// File: verilog/afic_frame_rx.sv
// Assembles nine-byte command frames and checks their checksum
`timescale 1ns/10ps
`include "afic_defs.svh"
module afic_frame_rx (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_valid,
  afic_frame_if.rx        fi
);
  logic [3:0]  cnt;
  logic [63:0] body;

  ////////////////////////////////////////////////////////////////////////////
  // Byte collection, most significant value byte first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= 4'h0;
      body <= 64'h0000_0000_0000_0000;
    end else if (rx_valid) begin
      if (cnt == `AFIC_FRAME_BODY) begin
        cnt <= 4'h0;
      end else begin
        body <= {body[55:0], rx_byte};
        cnt  <= cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame hand-over on the checksum byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fi.frm_valid  <= 1'b0;
      fi.frm_chk_ok <= 1'b0;
      fi.frm        <= '0;
    end else begin
      fi.frm_valid <= rx_valid && (cnt == `AFIC_FRAME_BODY);
      if (rx_valid && (cnt == `AFIC_FRAME_BODY)) begin
        fi.frm        <= body;
        fi.frm_chk_ok <= (afic_pkg::frame_sum(body) == rx_byte);
      end
    end
  end
endmodule

// File: verilog/afic_pkg.sv
// Types and shared arithmetic of the command executor
package afic_pkg;

  typedef enum logic [1:0] {
    AFIC_IDLE  = 2'b00,
    AFIC_EXEC  = 2'b01,
    AFIC_REPLY = 2'b11
  } afic_state_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } afic_frame_s;

  // Low eight bits of the sum of eight bytes
  function automatic logic [7:0] frame_sum(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + b[i*8 +: 8];
    end
    return s;
  endfunction

endpackage

// File: verilog/afic_reply_tx.sv
// Sends nine-byte reply frames with valid and ready
`timescale 1ns/10ps
module afic_reply_tx (
  input  wire logic       clk,
  input  wire logic       rst,
  output logic      [7:0] tx_byte,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  afic_frame_if.tx        fi
);
  logic [71:0] sh;
  logic [3:0]  idx;

  assign fi.rep_busy = tx_valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh       <= 72'h00_0000_0000_0000_0000;
      idx      <= 4'h0;
      tx_byte  <= 8'h00;
      tx_valid <= 1'b0;
    end else if (!tx_valid) begin
      if (fi.rep_start) begin
        tx_byte  <= fi.rep_bytes[63:56];
        sh       <= {fi.rep_bytes[55:0], afic_pkg::frame_sum(fi.rep_bytes), 8'h00};
        idx      <= 4'h0;
        tx_valid <= 1'b1;
      end
    end else if (tx_ready) begin
      if (idx == 4'h8) begin
        tx_valid <= 1'b0;
      end else begin
        tx_byte <= sh[71:64];
        sh      <= {sh[63:0], 8'h00};
        idx     <= idx + 4'h1;
      end
    end
  end
endmodule
